// >>> src/cboa_pkg.sv
package cboa_pkg;

    // ****************************************
    // control byte layout
    // ****************************************
    localparam int CTRL_W = 8;
    localparam int CTRL_SEL_MSB = 7;
    localparam int CTRL_SEL_LSB = 3;
    localparam int CHAN_W = 3;
    localparam int THR_W = 8;
    localparam int RES_W = 10;
    localparam int RES_CMP_LSB = 2;

    // ****************************************
    // reset values and channel codes
    // ****************************************
    localparam logic [2:0] CHAN_RST = 3'h0;
    localparam logic [7:0] THR_RST = 8'h99;
    localparam logic [2:0] CHAN_TEMP = 3'h0;
    localparam logic [2:0] CHAN_IN1 = 3'h1;
    localparam logic [2:0] CHAN_IN4 = 3'h4;
    localparam logic [2:0] CHAN_RSV_A = 3'h5;
    localparam logic [2:0] CHAN_RSV_B = 3'h6;
    localparam logic [2:0] CHAN_BANDGAP = 3'h7;

    // ****************************************
    // timing
    // ****************************************
    localparam int CLK_MHZ = 40;
    localparam int TEMP_CONV_US = 27;
    localparam int ANA_CONV_US = 9;
    localparam int TEMP_CONV_CYC = TEMP_CONV_US * CLK_MHZ;
    localparam int ANA_CONV_CYC = ANA_CONV_US * CLK_MHZ;
    localparam int CONV_CNT_W = 11;

    typedef enum logic [1:0] {
        CBOA_IDLE = 2'b00,
        CBOA_CONV = 2'b01,
        CBOA_DONE = 2'b11
    } cboa_conv_t;

endpackage

// >>> src/cboa_pin_sync.sv
`timescale 1ns/10ps
module cboa_pin_sync #(
    parameter int W = 1,
    parameter logic RST_VAL = 1'b0
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] next_q;

    // ****************************************
    // three stages, change taken once last two agree
    // ****************************************
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            always_comb begin
                next_q[i] = (s2[i] == s3[i]) ? s3[i] : q[i];
            end
        end
    endgenerate

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s1 <= {W{RST_VAL}};
            s2 <= {W{RST_VAL}};
            s3 <= {W{RST_VAL}};
            q <= {W{RST_VAL}};
        end else begin
            s1 <= d;
            s2 <= s1;
            s3 <= s2;
            q <= next_q;
        end
    end
endmodule

// >>> src/cboa_serial.sv
`timescale 1ns/10ps
module cboa_serial
    import cboa_pkg::*;
(
    input wire logic sclk,
    input wire logic rst_b,
    input wire logic din,
    input wire logic rd_wr,
    input wire logic [cboa_pkg::RES_W-1:0] result,
    input wire logic result_tgl,
    output logic [cboa_pkg::CTRL_W-1:0] ctrl_byte,
    output logic ctrl_tgl,
    output logic dout
);
    import cboa_pkg::*;

    logic [CTRL_W-1:0] sh_in;
    logic [2:0] bit_cnt;
    logic [CTRL_W-1:0] next_sh_in;
    logic [2:0] next_bit_cnt;
    logic [CTRL_W-1:0] next_ctrl_byte;
    logic next_ctrl_tgl;
    logic res_tgl_s;
    logic res_tgl_seen;
    logic [RES_W-1:0] shadow;
    logic [RES_W-1:0] sh_out;
    logic rd_active;
    logic next_res_tgl_seen;
    logic [RES_W-1:0] next_shadow;
    logic [RES_W-1:0] next_sh_out;
    logic next_rd_active;
    logic next_dout;
    logic rd_clr_b;

    // ****************************************
    // write side: sampled on rising sclk
    // ****************************************
    always_comb begin
        next_sh_in = sh_in;
        next_bit_cnt = bit_cnt;
        next_ctrl_byte = ctrl_byte;
        next_ctrl_tgl = ctrl_tgl;
        if (rd_wr) begin
            next_bit_cnt = 3'h0;
        end else begin
            next_sh_in = {sh_in[CTRL_W-2:0], din};
            next_bit_cnt = bit_cnt + 3'h1;
            if (bit_cnt == 3'h7) begin
                // byte held stable until the next toggle
                next_ctrl_byte = {sh_in[CTRL_W-2:0], din};
                next_ctrl_tgl = ~ctrl_tgl;
            end
        end
    end

    always_ff @(posedge sclk or negedge rst_b) begin
        if (!rst_b) begin
            sh_in <= 8'h00;
            bit_cnt <= 3'h0;
            ctrl_byte <= 8'h00;
            ctrl_tgl <= 1'b0;
        end else begin
            sh_in <= next_sh_in;
            bit_cnt <= next_bit_cnt;
            ctrl_byte <= next_ctrl_byte;
            ctrl_tgl <= next_ctrl_tgl;
        end
    end

    cboa_pin_sync #(.W(1), .RST_VAL(1'b0)) u_res_sync (
        .clk(sclk),
        .rst_b(rst_b),
        .d(result_tgl),
        .q(res_tgl_s)
    );

    // ****************************************
    // read side: driven on falling sclk
    // ****************************************
    always_comb begin
        next_res_tgl_seen = res_tgl_s;
        next_shadow = (res_tgl_s != res_tgl_seen) ? result : shadow;
        next_rd_active = rd_wr;
        next_sh_out = sh_out;
        next_dout = dout;
        if (rd_wr && !rd_active) begin
            next_dout = shadow[RES_W-1];
            next_sh_out = {shadow[RES_W-2:0], 1'b0};
        end else if (rd_wr) begin
            next_dout = sh_out[RES_W-1];
            next_sh_out = {sh_out[RES_W-2:0], 1'b0};
        end
    end

    always_ff @(negedge sclk or negedge rst_b) begin
        if (!rst_b) begin
            res_tgl_seen <= 1'b0;
            shadow <= 10'h000;
            sh_out <= 10'h000;
            dout <= 1'b0;
        end else begin
            res_tgl_seen <= next_res_tgl_seen;
            shadow <= next_shadow;
            sh_out <= next_sh_out;
            dout <= next_dout;
        end
    end

    // frame marker clears while read/write is low, as sclk may stand still then
    assign rd_clr_b = rst_b && rd_wr;

    always_ff @(negedge sclk or negedge rd_clr_b) begin
        if (!rd_clr_b) begin
            rd_active <= 1'b0;
        end else begin
            rd_active <= next_rd_active;
        end
    end
endmodule

// >>> src/cboa_alarm.sv
`timescale 1ns/10ps
// What this block does
// - one serial byte loads one of two registers
// - top five bits zero: load channel select if the code is a valid channel
// - channel codes: sensor, inputs, bandgap reference
// - bandgap code routes reference to converter
// - channel select resets to temperature sensor
// - any top bit set: load threshold
// - temperature result above threshold drives alarm low
// - read end or a temperature reading not above threshold releases alarm
// - threshold resets to 153
// - falling convert start begins; low at end powers down
// - data in on rising, out on falling sclk
// - read ends on rising read/write edge
module cboa_alarm
    import cboa_pkg::*;
#(
    parameter int N_CHAN = 4
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic sclk,
    input wire logic din,
    input wire logic rd_wr,
    input wire logic convert_start_n,
    input wire logic [cboa_pkg::RES_W-1:0] adc_result,
    output logic dout,
    output logic dout_oe,
    output logic [cboa_pkg::CHAN_W-1:0] mux_sel,
    output logic ref_route,
    output logic busy,
    output logic power_down,
    output logic over_temp_alarm_n
);
    import cboa_pkg::*;

    generate
        if (N_CHAN != 1 && N_CHAN != 4) begin : g_bad_chan
            $error("N_CHAN must be 1 or 4");
        end
        // the counter must hold the longer conversion
        if (TEMP_CONV_CYC > (1 << CONV_CNT_W) || ANA_CONV_CYC > (1 << CONV_CNT_W)) begin : g_bad_cnt
            $error("conversion counter too narrow");
        end
        if (RES_W - RES_CMP_LSB != THR_W || CTRL_W != THR_W) begin : g_bad_width
            $error("result, threshold and control widths disagree");
        end
    endgenerate

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic chan_ok(input logic [CHAN_W-1:0] c);
        logic ok;
        ok = 1'b1;
        if (c == CHAN_RSV_A || c == CHAN_RSV_B) begin
            ok = 1'b0;
        end
        if (N_CHAN == 1 && c > CHAN_IN1 && c <= CHAN_IN4) begin
            ok = 1'b0;
        end
        return ok;
    endfunction

    logic [CTRL_W-1:0] ctrl_byte_l;
    logic ctrl_tgl_l;
    logic [CTRL_W-1:0] ctrl_byte_s;
    logic ctrl_tgl_s;
    logic rd_wr_s;
    logic cs_n_s;
    logic rd_wr_q;
    logic cs_n_q;
    logic ctrl_seen;
    logic [RES_W-1:0] result;
    logic result_tgl;

    // ****************************************
    // serial port on the link clock
    // ****************************************
    cboa_serial u_serial (
        .sclk(sclk),
        .rst_b(rst_b),
        .din(din),
        .rd_wr(rd_wr),
        .result(result),
        .result_tgl(result_tgl),
        .ctrl_byte(ctrl_byte_l),
        .ctrl_tgl(ctrl_tgl_l),
        .dout(dout)
    );

    // byte is stable well before the toggle is seen here
    cboa_pin_sync #(.W(1), .RST_VAL(1'b0)) u_ctrl_sync (
        .clk(clk),
        .rst_b(rst_b),
        .d(ctrl_tgl_l),
        .q(ctrl_tgl_s)
    );

    cboa_pin_sync #(.W(1), .RST_VAL(1'b0)) u_rdwr_sync (
        .clk(clk),
        .rst_b(rst_b),
        .d(rd_wr),
        .q(rd_wr_s)
    );

    cboa_pin_sync #(.W(1), .RST_VAL(1'b1)) u_cs_sync (
        .clk(clk),
        .rst_b(rst_b),
        .d(convert_start_n),
        .q(cs_n_s)
    );

    assign ctrl_byte_s = ctrl_byte_l;

    // ****************************************
    // registers loaded from the control byte
    // ****************************************
    logic [CHAN_W-1:0] next_mux_sel;
    logic [THR_W-1:0] thr;
    logic [THR_W-1:0] next_thr;
    logic next_ref_route;
    logic next_ctrl_seen;
    logic ctrl_evt;

    always_comb begin
        ctrl_evt = ctrl_tgl_s != ctrl_seen;
        next_ctrl_seen = ctrl_tgl_s;
        next_mux_sel = mux_sel;
        next_thr = thr;
        if (ctrl_evt) begin
            if (ctrl_byte_s[CTRL_SEL_MSB:CTRL_SEL_LSB] == 5'h00) begin
                if (chan_ok(ctrl_byte_s[CHAN_W-1:0])) begin
                    next_mux_sel = ctrl_byte_s[CHAN_W-1:0];
                end
            end else begin
                next_thr = ctrl_byte_s;
            end
        end
        next_ref_route = next_mux_sel == CHAN_BANDGAP;
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_seen <= 1'b0;
            mux_sel <= CHAN_RST;
            thr <= THR_RST;
            ref_route <= 1'b0;
        end else begin
            ctrl_seen <= next_ctrl_seen;
            mux_sel <= next_mux_sel;
            thr <= next_thr;
            ref_route <= next_ref_route;
        end
    end

    // ****************************************
    // conversion sequencing
    // ****************************************
    cboa_conv_t st;
    cboa_conv_t next_st;
    logic [CONV_CNT_W-1:0] cnt;
    logic [CONV_CNT_W-1:0] next_cnt;
    logic conv_temp;
    logic next_conv_temp;
    logic next_busy;
    logic next_power_down;
    logic [RES_W-1:0] next_result;
    logic next_result_tgl;
    logic next_cs_n_q;
    logic cs_fall;
    logic conv_end;

    always_comb begin
        cs_fall = cs_n_q && !cs_n_s;
        next_cs_n_q = cs_n_s;
        next_st = st;
        next_cnt = cnt;
        next_conv_temp = conv_temp;
        next_busy = busy;
        next_power_down = power_down;
        conv_end = 1'b0;
        case (st)
            CBOA_IDLE: begin
                if (cs_fall) begin
                    next_st = CBOA_CONV;
                    next_conv_temp = mux_sel == CHAN_TEMP;
                    next_cnt = (mux_sel == CHAN_TEMP) ? CONV_CNT_W'(TEMP_CONV_CYC - 1)
                        : CONV_CNT_W'(ANA_CONV_CYC - 1);
                    next_busy = 1'b1;
                    next_power_down = 1'b0;
                end
            end
            CBOA_CONV: begin
                if (cnt == '0) begin
                    next_st = CBOA_DONE;
                end else begin
                    next_cnt = cnt - CONV_CNT_W'(1);
                end
            end
            CBOA_DONE: begin
                conv_end = 1'b1;
                next_st = CBOA_IDLE;
                next_busy = 1'b0;
                next_power_down = !cs_n_s;
            end
            default: begin
                next_st = CBOA_IDLE;
                next_busy = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st <= CBOA_IDLE;
            cnt <= '0;
            conv_temp <= 1'b0;
            busy <= 1'b0;
            power_down <= 1'b0;
            cs_n_q <= 1'b1;
        end else begin
            st <= next_st;
            cnt <= next_cnt;
            conv_temp <= next_conv_temp;
            busy <= next_busy;
            power_down <= next_power_down;
            cs_n_q <= next_cs_n_q;
        end
    end

    // ****************************************
    // result hold for the read side
    // ****************************************
    always_comb begin
        next_result = result;
        next_result_tgl = result_tgl;
        if (conv_end) begin
            // word and toggle move together; the link side copies only after the toggle
            next_result = adc_result;
            next_result_tgl = ~result_tgl;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            result <= 10'h000;
            result_tgl <= 1'b0;
        end else begin
            result <= next_result;
            result_tgl <= next_result_tgl;
        end
    end

    // ****************************************
    // read end detect and data pin enable
    // ****************************************
    logic next_rd_wr_q;
    logic next_dout_oe;
    logic rd_end;

    always_comb begin
        rd_end = rd_wr_s && !rd_wr_q;
        next_rd_wr_q = rd_wr_s;
        next_dout_oe = rd_wr_s;
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rd_wr_q <= 1'b0;
            dout_oe <= 1'b0;
        end else begin
            rd_wr_q <= next_rd_wr_q;
            dout_oe <= next_dout_oe;
        end
    end

    // ****************************************
    // over-temperature alarm
    // ****************************************
    logic next_alarm_n;

    always_comb begin
        next_alarm_n = over_temp_alarm_n;
        if (rd_end) begin
            next_alarm_n = 1'b1;
        end
        // a temperature measurement in the same cycle wins over the read end
        if (conv_end && conv_temp) begin
            next_alarm_n = !(adc_result[RES_W-1:RES_CMP_LSB] > thr);
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            over_temp_alarm_n <= 1'b1;
        end else begin
            over_temp_alarm_n <= next_alarm_n;
        end
    end
endmodule

// >>> test/cboa_alarm_props.sv
`timescale 1ns/10ps
module cboa_alarm_props
    import cboa_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic sclk,
    input wire logic din,
    input wire logic rd_wr,
    input wire logic convert_start_n,
    input wire logic [cboa_pkg::CHAN_W-1:0] mux_sel,
    input wire logic ref_route,
    input wire logic busy,
    input wire logic power_down,
    input wire logic over_temp_alarm_n
);
    // ****
    // helpers
    // ****
    logic [7:0] sh;
    logic [2:0] chan;
    logic [10:0] bcnt;
    logic [3:0] rd_age;
    logic rd_q;
    logic cs_q;
    // byte stays put long after the apply, so no sync needed here
    always_ff @(posedge sclk or negedge rst_b) begin
        if (!rst_b) begin
            sh <= 8'h00;
        end else if (!rd_wr) begin
            sh <= {sh[6:0], din};
        end
    end
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rd_q <= 1'b0;
            cs_q <= 1'b1;
            chan <= 3'h0;
            bcnt <= 11'h000;
            rd_age <= 4'hf;
        end else begin
            rd_q <= rd_wr;
            cs_q <= convert_start_n;
            rd_age <= (rd_wr && !rd_q) ? 4'h0 : (rd_age == 4'hf ? rd_age : rd_age + 4'h1);
            bcnt <= busy ? bcnt + 11'h001 : 11'h000;
            chan <= (busy && bcnt == 11'h000) ? mux_sel : chan;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    // ****
    // checks
    // ****
    chan_rsv_a: assert property ($changed(mux_sel) |-> mux_sel != 3'h5 && mux_sel != 3'h6)
        else $error("reserved channel code loaded");
    mux_write_a: assert property ($changed(mux_sel) |-> sh[7:3] == 5'h00 && mux_sel == sh[2:0])
        else $error("channel select changed without matching byte");
    ref_route_a: assert property (ref_route == (mux_sel == 3'h7))
        else $error("reference route disagrees with channel");
    alarm_temp_a: assert property ($fell(over_temp_alarm_n) |-> $fell(busy) && chan == 3'h0)
        else $error("alarm set outside a temperature result");
    alarm_rel_a: assert property ($rose(over_temp_alarm_n) |-> $fell(busy) || rd_age < 4'h9)
        else $error("alarm released without cause");
    rd_clear_a: assert property ($rose(rd_q) |-> ##[1:8] over_temp_alarm_n)
        else $error("read end did not clear alarm");
    conv_start_a: assert property ($fell(cs_q) && !busy |-> ##[2:6] busy)
        else $error("conversion did not start");
    busy_len_a: assert property ($fell(busy) |->
        (chan == 3'h0 ? bcnt inside {[1078:1083]} : bcnt inside {[358:363]}))
        else $error("conversion length wrong");
    pdown_a: assert property ($fell(busy) |-> power_down == !$past(convert_start_n, 4))
        else $error("power down state wrong at conversion end");
    cover property ($fell(over_temp_alarm_n));
    cover property ($rose(power_down));
    cover property ($rose(ref_route));
endmodule

// >>> test/cboa_host.sv
`timescale 1ns/10ps
module cboa_host (
    input wire logic dout_in,
    output logic sclk,
    output logic din,
    output logic rd_wr,
    output logic [9:0] rd_data
);
    // ****
    // host serial port, clock stands still between frames
    // ****
    initial begin
        sclk = 1'b0;
        din = 1'b0;
        rd_wr = 1'b0;
        rd_data = 10'h000;
    end
    task automatic write_byte(input logic [7:0] b);
        #7;
        rd_wr = 1'b0;
        for (int i = 7; i >= 0; i--) begin
            din = b[i];
            #40 sclk = 1'b1;
            #40 sclk = 1'b0;
        end
        din = ~din;
    endtask
    task automatic read_frame();
        #7;
        rd_wr = 1'b1;
        #40;
        repeat (10) begin
            sclk = 1'b1;
            #40 sclk = 1'b0;
            // dout moves on the falling edge, so take it half a phase later
            #20 rd_data = {rd_data[8:0], dout_in};
            #20;
        end
        rd_wr = 1'b0;
    endtask
endmodule

// >>> test/test_control_byte_overtemp_alarm.sv
`timescale 1ns/10ps
module test_control_byte_overtemp_alarm;
    import cboa_pkg::*;
    logic clk, rst_b, cs_n, sclk, din, rd_wr, dout, dout_oe, ref_route, busy, pd, alarm_n;
    logic [9:0] adc, rd_word;
    logic [2:0] mux, mux_p, cur;
    logic [7:0] thr;
    logic al_p;
    logic [2:0] mq[$];
    logic aq[$];
    int failures, n_checks, cyc, seed;
    cboa_host cboa_host_inst (.dout_in(dout), .sclk(sclk), .din(din), .rd_wr(rd_wr),
        .rd_data(rd_word));
    cboa_alarm cboa_alarm_inst (.clk(clk), .rst_b(rst_b), .sclk(sclk), .din(din), .rd_wr(rd_wr),
        .convert_start_n(cs_n), .adc_result(adc), .dout(dout), .dout_oe(dout_oe), .mux_sel(mux),
        .ref_route(ref_route), .busy(busy), .power_down(pd), .over_temp_alarm_n(alarm_n));
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // ****
    // tasks
    // ****
    task automatic check(input logic [9:0] got, input logic [9:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic wait_clk(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic wr(input logic [7:0] b);
        if (b[7:3] == 5'h00 && b[2:0] != 3'h5 && b[2:0] != 3'h6 && b[2:0] != cur) begin
            mq.push_back(b[2:0]);
        end
        if (b[7:3] == 5'h00 && b[2:0] != 3'h5 && b[2:0] != 3'h6) cur = b[2:0];
        cboa_host_inst.write_byte(b);
        wait_clk(12);
    endtask
    task automatic conv(input logic [9:0] r, input logic keep);
        int n;
        adc = r;
        cs_n = 1'b1;
        wait_clk(20);
        cs_n = 1'b0;
        n = 0;
        while (busy !== 1'b1 && n < 20) begin
            @(negedge clk);
            n++;
        end
        if (!keep) cs_n = 1'b1;
        n = 0;
        while (busy !== 1'b0 && n < 1200) begin
            @(negedge clk);
            n++;
        end
        check({busy, pd}, {1'b0, keep});
    endtask
    // ****
    // result watcher and timeout
    // ****
    always @(negedge clk) begin
        if (rst_b && mux !== mux_p) check(mux, mq.size() ? mq.pop_front() : mux_p);
        if (rst_b && alarm_n !== al_p) check(alarm_n, aq.size() ? aq.pop_front() : al_p);
        mux_p = mux;
        al_p = alarm_n;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 40000) begin
            failures++;
            end_sim();
        end
    end
    // ****
    // scenarios
    // ****
    initial begin
        rst_b = 1'b0;
        cs_n = 1'b1;
        adc = 10'h000;
        cur = 3'h0;
        mux_p = 3'h0;
        al_p = 1'b1;
        seed = 10;
        wait_clk(6);
        rst_b = 1'b1;
        check({ref_route, alarm_n, mux}, {1'b0, 1'b1, CHAN_RST});
        $display("reset test done");
        // default threshold: equal keeps alarm off, one above trips it
        conv({8'h99, 2'b11}, 1'b0);
        aq.push_back(1'b0);
        conv({8'h9a, 2'b00}, 1'b0);
        aq.push_back(1'b1);
        conv({8'h99, 2'b00}, 1'b0);
        aq.push_back(1'b0);
        conv(10'h3ff, 1'b1);
        aq.push_back(1'b1);
        cboa_host_inst.read_frame();
        wait_clk(12);
        $display("alarm test done");
        for (int c = 1; c < 8; c++) begin
            wr({5'h00, c[2:0]});
            check({ref_route, mux}, {cur == 3'h7, cur});
            if (c == 1) conv(10'h2c5, 1'b0);
        end
        wr(8'h00);
        // the writes above clocked the link, so the analog result is on the read side
        fork
            cboa_host_inst.read_frame();
            begin
                wait_clk(12);
                check(dout_oe, 1'b1);
            end
        join
        check(rd_word, 10'h2c5);
        wait_clk(12);
        check(dout_oe, 1'b0);
        $display("channel test done");
        thr = (8'($random(seed)) & 8'hfe) | 8'h08;
        wr(thr);
        check(mux, 3'h0);
        conv({thr, 2'b11}, 1'b0);
        aq.push_back(1'b0);
        conv({thr + 8'h01, 2'b00}, 1'b0);
        aq.push_back(1'b1);
        conv({thr - 8'h01, 2'b11}, 1'b0);
        $display("threshold test done");
        // a mid-run reset must bring the threshold back to its power-on value
        wr(8'hff);
        rst_b = 1'b0;
        wait_clk(3);
        rst_b = 1'b1;
        check({ref_route, alarm_n, mux}, {1'b0, 1'b1, CHAN_RST});
        aq.push_back(1'b0);
        conv({8'h9a, 2'b00}, 1'b0);
        wait_clk(2);
        check(mq.size() + aq.size(), 0);
        $display("reset rerun test done");
        end_sim();
    end
endmodule
bind cboa_alarm cboa_alarm_props cboa_alarm_props_inst (.clk(clk), .rst_b(rst_b), .sclk(sclk),
    .din(din), .rd_wr(rd_wr), .convert_start_n(convert_start_n), .mux_sel(mux_sel),
    .ref_route(ref_route), .busy(busy), .power_down(power_down),
    .over_temp_alarm_n(over_temp_alarm_n));
